// ### sfrp_pkg.sv
// shared constants and types for the serial flash link, both ends
package sfrp_pkg;

    // ***********************************************
    // command opcodes, one per recognised instruction
    // ***********************************************
    localparam logic [7:0] OPC_FAST_READ    = 8'h0b;
    localparam logic [7:0] OPC_TWO_LINE     = 8'h3b;
    localparam logic [7:0] OPC_LOCK_READ    = 8'he8;
    localparam logic [7:0] OPC_ONETIME_READ = 8'h4b;
    localparam logic [7:0] OPC_PAGE_WRITE   = 8'h02;
    localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;

    // ***********************************************
    // array geometry and lock byte layout
    // ***********************************************
    localparam int         PAGE_BYTES      = 256;
    localparam int         NUM_SECTORS     = 16;
    localparam int         SECT_LSB        = 16;
    localparam int         OTP_BYTES       = 65;
    localparam logic [6:0] OTP_LAST        = 7'h40;
    localparam int         LOCK_DOWN_BIT   = 1;
    localparam int         WRITE_LOCK_BIT  = 0;
    localparam logic [1:0] LOCK_RST        = 2'h0;
    localparam logic [7:0] ERASED_BYTE     = 8'hff;

    // ***********************************************
    // timing
    // ***********************************************
    localparam int CLK_NS       = 40;
    localparam int PROG_TIME_NS = 800000;
    localparam int PROG_CYCLES  = PROG_TIME_NS / CLK_NS;
    localparam int SCK_HALF     = 8;

    // ***********************************************
    // controller registers: byte offsets and fields
    // ***********************************************
    localparam logic [7:0] REG_XFER   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_RXDATA = 8'h08;
    localparam int         XF_DUAL    = 8;
    localparam int         XF_HOLD    = 9;
    localparam int         XF_STOP    = 10;
    localparam int         ST_BUSY    = 0;
    localparam int         ST_SELECT  = 1;

    typedef enum logic [4:0] {
        CMD_FAST = 5'b00001,
        CMD_DUAL = 5'b00010,
        CMD_LOCK = 5'b00100,
        CMD_OTP  = 5'b01000,
        CMD_PROG = 5'b10000
    } sfrp_cmd_e;

endpackage

// ### sfrp_if.sv
// serial link between the flash device and its bus master
`timescale 1ns/10ps
interface sfrp_if;
    logic cs_n;
    logic sclk;
    logic host_dq0;
    logic host_dq0_oe_n;
    logic dev_dq0;
    logic dev_dq0_oe_n;
    logic dev_dq1;
    logic dev_dq1_oe_n;
    logic dq0;
    logic dq1;

    // wire levels; device wins data_line0 only in two-line output, idle lines pull high
    assign dq0 = !dev_dq0_oe_n ? dev_dq0 : (!host_dq0_oe_n ? host_dq0 : 1'b1);
    assign dq1 = !dev_dq1_oe_n ? dev_dq1 : 1'b1;

    modport host (output cs_n, sclk, host_dq0, host_dq0_oe_n, input dq0, dq1);
    modport device (input cs_n, sclk, dq0, output dev_dq0, dev_dq0_oe_n, dev_dq1, dev_dq1_oe_n);
endinterface

// ### sfrp_flash_dev.sv
// flash device end: command decode, reads, page program and sector locks
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/10ps
module sfrp_flash_dev
    import sfrp_pkg::*;
#(
    parameter int MEM_AW   = 10,
    parameter int PROG_CYC = PROG_CYCLES
) (
    input  wire logic       CLOCK_I,
    input  wire logic       SYS_RST_I,
    sfrp_if.device          LINK,
    input  wire logic [2:0] BLOCK_PROTECT_I,
    input  wire logic       LOCK_WR_I,
    input  wire logic [3:0] LOCK_SECT_I,
    input  wire logic [1:0] LOCK_DATA_I,
    output logic            WIP_O,
    output logic            WEL_O
);

    typedef enum logic [5:0] {
        ST_OPC   = 6'b000001,
        ST_ADDR  = 6'b000010,
        ST_DUMMY = 6'b000100,
        ST_OUT   = 6'b001000,
        ST_IN    = 6'b010000,
        ST_SKIP  = 6'b100000
    } sfrp_dst_e;

    // ***********************************************
    // link synchronisers and edge detection
    // ***********************************************
    logic [2:0]  s1_q, s2_q, s3_q;          // {dq0, sclk, cs_n}
    logic        cs_act, rise, fall, cs_up, last_bit;
    logic [7:0]  byte_in;

    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            s1_q <= 3'h1;
            s2_q <= 3'h1;
            s3_q <= 3'h1;
        end else begin
            s1_q <= {LINK.dq0, LINK.sclk, LINK.cs_n};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign cs_act   = !s2_q[0];
    assign cs_up    = s2_q[0] && !s3_q[0];
    assign rise     = cs_act && s2_q[1] && !s3_q[1];
    assign fall     = cs_act && !s2_q[1] && s3_q[1];

    // ***********************************************
    // storage and control state
    // ***********************************************
    sfrp_dst_e   state_q;
    sfrp_cmd_e   cmd_q;
    logic [2:0]  bit_q;
    logic [7:0]  sh_q;
    logic [1:0]  abyte_q;
    logic [23:0] addr_q;
    logic [7:0]  col_q;
    logic        got_q;
    logic [7:0]  out_q;
    logic [2:0]  ocnt_q;
    logic        dq0_q, dq1_q, oe0_n_q, oe1_n_q;
    logic        wel_q, wip_q;
    logic [31:0] pcnt_q;
    logic [MEM_AW-9:0] page_q;
    logic [7:0]  pbuf_q [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] pval_q;
    logic [7:0]  mem_q [2**MEM_AW];
    logic [1:0]  lock_q [NUM_SECTORS];
    logic [7:0]  otp_q [OTP_BYTES];
    logic [7:0]  fetch;
    logic [7:0]  cur;
    logic [3:0]  sect;
    logic        prot, walk;
    logic [5:0]  dec;                        // {known, command} of the byte just taken

    assign byte_in  = {sh_q[6:0], s2_q[2]};
    assign last_bit = rise && (bit_q == 3'h7);
    assign sect     = addr_q[SECT_LSB+3:SECT_LSB];
    assign walk     = wip_q && (pcnt_q < 32'(PAGE_BYTES));
    assign WIP_O    = wip_q;
    assign WEL_O    = wel_q;

    // the opcode byte selects one command; anything else is skipped
    function automatic logic [5:0] decode(input logic [7:0] opc);
        if (opc == OPC_FAST_READ)         decode = {1'b1, CMD_FAST};
        else if (opc == OPC_TWO_LINE)     decode = {1'b1, CMD_DUAL};
        else if (opc == OPC_LOCK_READ)    decode = {1'b1, CMD_LOCK};
        else if (opc == OPC_ONETIME_READ) decode = {1'b1, CMD_OTP};
        else if (opc == OPC_PAGE_WRITE)   decode = {1'b1, CMD_PROG};
        else                              decode = 6'h00;
    endfunction

    // protected region grows downward from the top sector with the setting
    function automatic logic protected_sect(input logic [2:0] bp, input logic [3:0] s);
        if (bp == 3'h0) protected_sect = 1'b0;
        else protected_sect = ({4'h0, s} + (8'h01 << (bp - 3'h1))) >= 8'(NUM_SECTORS);
    endfunction

    assign prot = protected_sect(BLOCK_PROTECT_I, sect);
    assign dec  = decode(byte_in);

    // ***********************************************
    // serial input shifting
    // ***********************************************
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            bit_q <= 3'h0;
            sh_q  <= 8'h00;
        end else if (!cs_act) begin
            bit_q <= 3'h0;
        end else if (rise) begin
            bit_q <= bit_q + 3'h1;
            sh_q  <= byte_in;
        end
    end

    // ***********************************************
    // command sequencing and address counter
    // ***********************************************
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            state_q <= ST_OPC;
            cmd_q   <= CMD_FAST;
            abyte_q <= 2'h0;
            addr_q  <= 24'h000000;
            col_q   <= 8'h00;
            got_q   <= 1'b0;
        end else if (!cs_act) begin
            state_q <= ST_OPC;
            abyte_q <= 2'h0;
            got_q   <= 1'b0;
        end else if (last_bit) begin
            case (state_q)
                ST_OPC: begin
                    // a running cycle is left alone, the request is dropped
                    if (dec[5] && !wip_q) begin
                        state_q <= ST_ADDR;
                        cmd_q   <= sfrp_cmd_e'(dec[4:0]);
                    end else begin
                        state_q <= ST_SKIP;
                    end
                end
                ST_ADDR: begin
                    addr_q  <= {addr_q[15:0], byte_in};
                    abyte_q <= abyte_q + 2'h1;
                    if (abyte_q == 2'h2) begin
                        col_q <= byte_in;
                        if (cmd_q == CMD_PROG) state_q <= ST_IN;
                        else if (cmd_q == CMD_LOCK) state_q <= ST_OUT;
                        else state_q <= ST_DUMMY;
                    end
                end
                ST_DUMMY: state_q <= ST_OUT;
                ST_IN: begin
                    got_q <= 1'b1;
                    col_q <= col_q + 8'h01;
                end
                default: state_q <= state_q;
            endcase
        end else if (fall && state_q == ST_OUT && ocnt_q == 3'h0) begin
            if (cmd_q == CMD_OTP) begin
                // no rollover: parks on the last byte
                if (addr_q[6:0] < OTP_LAST) addr_q <= {17'h00000, addr_q[6:0] + 7'h01};
                else addr_q <= {17'h00000, OTP_LAST};
            end else if (cmd_q != CMD_LOCK) begin
                addr_q <= {2'h0, addr_q[21:0] + 22'h000001};
            end
        end
    end

    // byte presented at the start of each output byte
    always_comb begin
        fetch = mem_q[addr_q[MEM_AW-1:0]];
        if (cmd_q == CMD_LOCK) fetch = {6'h00, lock_q[sect]};
        else if (cmd_q == CMD_OTP) begin
            if (addr_q[6:0] > OTP_LAST) fetch = otp_q[OTP_LAST];
            else fetch = otp_q[addr_q[6:0]];
        end
        cur = (ocnt_q == 3'h0) ? fetch : out_q;
    end

    // ***********************************************
    // serial output on falling clock edges
    // ***********************************************
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            out_q   <= 8'h00;
            ocnt_q  <= 3'h0;
            dq0_q   <= 1'b0;
            dq1_q   <= 1'b0;
            oe0_n_q <= 1'b1;
            oe1_n_q <= 1'b1;
        end else if (!cs_act) begin
            ocnt_q  <= 3'h0;
            oe0_n_q <= 1'b1;
            oe1_n_q <= 1'b1;
        end else if (fall && state_q == ST_OUT) begin
            oe1_n_q <= 1'b0;
            dq1_q   <= cur[7];
            if (cmd_q == CMD_DUAL) begin
                oe0_n_q <= 1'b0;
                dq0_q   <= cur[6];
                out_q   <= {cur[5:0], 2'h0};
                ocnt_q  <= (ocnt_q == 3'h3) ? 3'h0 : ocnt_q + 3'h1;
            end else begin
                out_q   <= {cur[6:0], 1'b0};
                ocnt_q  <= ocnt_q + 3'h1;
            end
        end
    end

    assign LINK.dev_dq0      = dq0_q;
    assign LINK.dev_dq1      = dq1_q;
    assign LINK.dev_dq0_oe_n = oe0_n_q;
    assign LINK.dev_dq1_oe_n = oe1_n_q;

    // ***********************************************
    // page latch: later bytes overwrite earlier ones
    // ***********************************************
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            pval_q <= '0;
            for (int i = 0; i < PAGE_BYTES; i++) pbuf_q[i] <= ERASED_BYTE;
        end else if (last_bit && state_q == ST_ADDR && abyte_q == 2'h2) begin
            pval_q <= '0;
        end else if (last_bit && state_q == ST_IN) begin
            pbuf_q[col_q] <= byte_in;
            pval_q[col_q] <= 1'b1;
        end
    end

    // ***********************************************
    // enable latch and timed program cycle
    // ***********************************************
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            wel_q  <= 1'b0;
            wip_q  <= 1'b0;
            pcnt_q <= 32'h0;
            page_q <= '0;
        end else if (wip_q) begin
            pcnt_q <= pcnt_q + 32'h1;
            if (pcnt_q == 32'(PROG_CYC - 1)) begin
                wip_q <= 1'b0;
                wel_q <= 1'b0;
            end
        end else if (last_bit && state_q == ST_OPC && byte_in == OPC_WRITE_ENABLE) begin
            wel_q <= 1'b1;
        end else if (cs_up && state_q == ST_IN && cmd_q == CMD_PROG) begin
            // only a whole-byte end with the latch set and an open sector programs
            if (bit_q == 3'h0 && got_q && wel_q && !prot
                && !lock_q[sect][WRITE_LOCK_BIT]) begin
                wip_q  <= 1'b1;
                pcnt_q <= 32'h0;
                page_q <= addr_q[MEM_AW-1:8];
            end
        end
    end

    // ***********************************************
    // array: one latched byte merged per cycle over the first PAGE_BYTES (256) busy cycles
    // ***********************************************
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            for (int i = 0; i < 2**MEM_AW; i++) mem_q[i] <= ERASED_BYTE;
        end else if (walk && pval_q[pcnt_q[7:0]]) begin
            mem_q[{page_q, pcnt_q[7:0]}] <= mem_q[{page_q, pcnt_q[7:0]}]
                                          & pbuf_q[pcnt_q[7:0]];
        end
    end

    // one-time area is never programmed here, so it reads erased
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            for (int i = 0; i < OTP_BYTES; i++) otp_q[i] <= ERASED_BYTE;
        end else begin
            otp_q <= otp_q;
        end
    end

    // ***********************************************
    // sector lock bytes, writable until the lock-down bit is set, which then clears only by reset
    // ***********************************************
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            for (int i = 0; i < NUM_SECTORS; i++) lock_q[i] <= LOCK_RST;
        end else if (LOCK_WR_I && !lock_q[LOCK_SECT_I][LOCK_DOWN_BIT]) begin
            lock_q[LOCK_SECT_I] <= LOCK_DATA_I;
        end
    end

endmodule

// ### sfrp_host_ctl.sv
// bus master end: byte shifter steered by APB registers
`timescale 1ns/10ps
module sfrp_host_ctl
    import sfrp_pkg::*;
#(
    parameter int HALF = SCK_HALF
) (
    input  wire logic        CLOCK_I,
    input  wire logic        SYS_RST_I,
    sfrp_if.host             LINK,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic [31:0]      PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O
);

    typedef enum logic [3:0] {
        HS_IDLE = 4'b0001,
        HS_LOW  = 4'b0010,
        HS_HIGH = 4'b0100,
        HS_GAP  = 4'b1000
    } sfrp_hst_e;

    sfrp_hst_e   st_q;
    logic [7:0]  div_q;
    logic        tick;
    logic [7:0]  tx_q, rx_q;
    logic [3:0]  left_q;
    logic        dual_q, hold_q, cs_n_q, sclk_q, dq0_q, oe_n_q;
    logic [10:0] xfer_q;
    logic [1:0]  s1_q, s2_q;                // {dq1, dq0}
    logic        wr_go, busy;

    assign busy  = (st_q != HS_IDLE);
    assign wr_go = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O && !busy
                   && (PADDR_I == REG_XFER);

    // ***********************************************
    // data line synchroniser and half-period divider
    // ***********************************************
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            s1_q <= 2'h3;
            s2_q <= 2'h3;
        end else begin
            s1_q <= {LINK.dq1, LINK.dq0};
            s2_q <= s1_q;
        end
    end

    // restarts with each byte so the first half period is whole
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) div_q <= 8'h00;
        else if (!busy || tick) div_q <= 8'h00;
        else div_q <= div_q + 8'h01;
    end
    assign tick = (div_q == 8'(HALF - 1));

    // ***********************************************
    // byte shifter; select only rises between whole bytes
    // ***********************************************
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            st_q   <= HS_IDLE;
            tx_q   <= 8'h00;
            rx_q   <= 8'h00;
            left_q <= 4'h0;
            dual_q <= 1'b0;
            hold_q <= 1'b0;
            cs_n_q <= 1'b1;
            sclk_q <= 1'b0;
            dq0_q  <= 1'b1;
            oe_n_q <= 1'b1;
        end else begin
            case (st_q)
                HS_IDLE: begin
                    if (wr_go && PWDATA_I[XF_STOP]) begin
                        st_q <= HS_GAP;
                    end else if (wr_go) begin
                        st_q   <= HS_LOW;
                        cs_n_q <= 1'b0;
                        tx_q   <= PWDATA_I[7:0];
                        dq0_q  <= PWDATA_I[7];
                        dual_q <= PWDATA_I[XF_DUAL];
                        hold_q <= PWDATA_I[XF_HOLD];
                        oe_n_q <= PWDATA_I[XF_DUAL]; // released for two-line input
                        left_q <= PWDATA_I[XF_DUAL] ? 4'h4 : 4'h8;
                    end
                end
                HS_LOW: if (tick) begin
                    sclk_q <= 1'b1;
                    st_q   <= HS_HIGH;
                    left_q <= left_q - 4'h1;
                    if (dual_q) rx_q <= {rx_q[5:0], s2_q[1], s2_q[0]};
                    else rx_q <= {rx_q[6:0], s2_q[1]};
                end
                HS_HIGH: if (tick) begin
                    sclk_q <= 1'b0;
                    if (left_q != 4'h0) begin
                        st_q  <= HS_LOW;
                        tx_q  <= {tx_q[6:0], 1'b0};
                        dq0_q <= tx_q[6];
                    end else if (hold_q) begin
                        // let go of data_line0 so a two-line reply never meets our drive
                        st_q   <= HS_IDLE;
                        oe_n_q <= 1'b1;
                    end else begin
                        st_q <= HS_GAP;
                    end
                end
                default: if (tick) begin
                    cs_n_q <= 1'b1;
                    oe_n_q <= 1'b1;
                    st_q   <= HS_IDLE;
                end
            endcase
        end
    end

    assign LINK.cs_n          = cs_n_q;
    assign LINK.sclk          = sclk_q;
    assign LINK.host_dq0      = dq0_q;
    assign LINK.host_dq0_oe_n = oe_n_q;

    // ***********************************************
    // APB slave: one wait state, unmapped answers error
    // ***********************************************
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            PREADY_O  <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O  <= 32'h0;
            xfer_q    <= 11'h000;
        end else begin
            PREADY_O <= PSEL_I && PENABLE_I && !PREADY_O;
            if (wr_go) xfer_q <= PWDATA_I[10:0];
            if (PSEL_I && PENABLE_I && !PREADY_O) begin
                PSLVERR_O <= 1'b0;
                PRDATA_O  <= 32'h0;
                if (PADDR_I == REG_XFER) PRDATA_O <= {21'h0, xfer_q};
                else if (PADDR_I == REG_STATUS) PRDATA_O <= {30'h0, !cs_n_q, busy};
                else if (PADDR_I == REG_RXDATA) PRDATA_O <= {24'h0, rx_q};
                else PSLVERR_O <= 1'b1;
            end
        end
    end

endmodule

// ### sfrp_link_props.sv
// checker: link timing and program cycle properties of the flash link
`timescale 1ns/10ps
module sfrp_link_props #(
    parameter int PROG_CYC = 300
) (
    input wire logic CLOCK_I,
    input wire logic SYS_RST_I,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic host_dq0_oe_n,
    input wire logic dev_dq0_oe_n,
    input wire logic dev_dq1,
    input wire logic dev_dq1_oe_n,
    input wire logic WIP_O,
    input wire logic WEL_O
);
    logic [31:0] run_q;
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (SYS_RST_I);
    // cycles spent with the program cycle running; too long to unroll in a property
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            run_q <= 32'h0;
        end else begin
            run_q <= WIP_O ? run_q + 32'h1 : 32'h0;
        end
    end
    // device drive stays inside frames and off the host sampling phase; program cycle has a cause and a fixed length
    a_release_deselect: assert property (cs_n [*4] |-> dev_dq1_oe_n && dev_dq0_oe_n)
        else $error("device drives while deselected");
    a_busy_silent: assert property (WIP_O |-> dev_dq1_oe_n && dev_dq0_oe_n)
        else $error("device drives during program cycle");
    a_wip_cause: assert property ($rose(WIP_O) |-> cs_n && WEL_O)
        else $error("program cycle started without cause");
    a_wip_length: assert property ($fell(WIP_O) |-> run_q == PROG_CYC && !WEL_O)
        else $error("program cycle length or latch wrong");
    a_dq1_fall_only: assert property (!dev_dq1_oe_n && sclk |-> $stable(dev_dq1))
        else $error("data_line1 moved while clock high");
    a_dq0_owner: assert property (!dev_dq0_oe_n |-> host_dq0_oe_n)
        else $error("both ends drive data_line0");
    a_dual_pair: assert property (!dev_dq0_oe_n |-> !dev_dq1_oe_n)
        else $error("two-line output on one line only");
    a_opcode_quiet: assert property ($fell(cs_n) |-> dev_dq1_oe_n [*8])
        else $error("device drives during opcode");
    // main scenarios reached
    cover property ($fell(WIP_O));
    cover property (!dev_dq0_oe_n && sclk);
    cover property (!dev_dq1_oe_n ##1 cs_n);
endmodule

// ### serial_flash_read_program_cmds_tb_top.sv
// testbench: both link ends, ordered through the host's register bus
`timescale 1ns/10ps
module serial_flash_read_program_cmds_tb_top;
    import sfrp_pkg::*;
    localparam int PCYC = 2000;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, lk_wr, write_in_progress, write_enable_latch;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic [2:0]  bp;
    logic [3:0]  lk_sect;
    logic [1:0]  lk_data;
    int          errors, checked;
    sfrp_if link ();
    sfrp_flash_dev #(.PROG_CYC(PCYC)) u_sfrp_flash_dev (.CLOCK_I(clk), .SYS_RST_I(rst),
        .LINK(link), .BLOCK_PROTECT_I(bp), .LOCK_WR_I(lk_wr), .LOCK_SECT_I(lk_sect),
        .LOCK_DATA_I(lk_data), .WIP_O(write_in_progress), .WEL_O(write_enable_latch));
    sfrp_host_ctl u_sfrp_host_ctl (.CLOCK_I(clk), .SYS_RST_I(rst), .LINK(link),
        .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr));
    sfrp_link_props #(.PROG_CYC(PCYC)) u_sfrp_link_props (.CLOCK_I(clk), .SYS_RST_I(rst),
        .cs_n(link.cs_n), .sclk(link.sclk), .host_dq0_oe_n(link.host_dq0_oe_n),
        .dev_dq0_oe_n(link.dev_dq0_oe_n), .dev_dq1(link.dev_dq1),
        .dev_dq1_oe_n(link.dev_dq1_oe_n), .WIP_O(write_in_progress), .WEL_O(write_enable_latch));
    // compare and count
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one bus transfer; an idle cycle follows so psel never toggles in one step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, wd};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        {psel, penable} <= 2'b00;
        @(posedge clk);
    endtask
    // one link byte, then poll until the shifter is idle; r ends with the received byte
    task automatic xfer(input logic [10:0] ctl);
        apb(1'b1, REG_XFER, {21'h0, ctl});
        do apb(1'b0, REG_STATUS, 32'h0); while (r[ST_BUSY] !== 1'b0);
        apb(1'b0, REG_RXDATA, 32'h0);
    endtask
    // raise select; the pause keeps the deselect gap above a half period
    task automatic stop;
        xfer(11'h400);
        repeat (16) @(posedge clk);
    endtask
    task automatic cmd(input logic [7:0] op, input logic [23:0] a, input bit dummy);
        xfer({3'b010, op});
        for (int i = 2; i >= 0; i--) xfer({3'b010, a[i*8 +: 8]});
        if (dummy) xfer(11'h2ff);
    endtask
    // read frame of n bytes, expected bytes packed high first
    task automatic rdf(input logic [7:0] op, input logic [23:0] a, input int n,
                       input logic [23:0] e);
        cmd(op, a, op != OPC_LOCK_READ);
        for (int i = 0; i < n; i++) begin
            xfer({2'b01, op == OPC_TWO_LINE, 8'hff});
            chk("rx", {24'h0, r[7:0]}, {24'h0, e[23-8*i -: 8]});
        end
        stop();
    endtask
    task automatic prog(input bit en, input logic [23:0] a, input logic [15:0] d, input int n);
        if (en) begin
            xfer({3'b010, OPC_WRITE_ENABLE});
            stop();
            chk("wel", 32'(write_enable_latch), 32'h1);
        end
        cmd(OPC_PAGE_WRITE, a, 1'b0);
        for (int i = 0; i < n; i++) xfer({3'b010, d[15-8*i -: 8]});
        stop();
    endtask
    task automatic idle;
        int n;
        n = 0;
        while (write_in_progress !== 1'b0 && n++ < 3000) @(posedge clk);
        chk("wip", 32'(write_in_progress), 32'h0);
        chk("wel", 32'(write_enable_latch), 32'h0);
    endtask
    task automatic lock(input logic [3:0] s, input logic [1:0] v);
        {lk_sect, lk_data, lk_wr} <= {s, v, 1'b1};
        @(posedge clk);
        lk_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic close_out;
        if (errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // free-running system clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // hang guard, well above the expected run length
    initial begin
        repeat (80000) @(posedge clk);
        errors++;
        close_out();
    end
    // main sequence
    initial begin
        {psel, penable, pwrite, lk_wr, paddr, pwdata, bp, lk_sect, lk_data} = '0;
        rst = 1'b1;
        errors = 0;
        checked = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, 8'h0c, 32'h0);
        chk("slverr", 32'(pslverr), 32'h1);
        prog(1'b0, 24'h000000, 16'h0000, 1);
        chk("wip_nowel", 32'(write_in_progress), 32'h0);
        prog(1'b1, 24'hc000ff, 16'ha51e, 2);
        chk("wip_run", 32'(write_in_progress), 32'h1);
        rdf(OPC_FAST_READ, 24'h0000ff, 1, 24'hff0000);
        idle();
        prog(1'b1, 24'h0000ff, 16'h0f00, 1);
        idle();
        rdf(OPC_FAST_READ, 24'h0000fe, 3, 24'hff05ff);
        rdf(OPC_FAST_READ, 24'h3fffff, 2, 24'hff1e00);
        rdf(OPC_TWO_LINE, 24'h3fffff, 2, 24'hff1e00);
        rdf(OPC_ONETIME_READ, 24'hffff80, 1, 24'hff0000);
        lock(4'h1, 2'b01);
        prog(1'b1, 24'h010000, 16'h0000, 1);
        chk("wip_lock", 32'(write_in_progress), 32'h0);
        lock(4'h1, 2'b11);
        lock(4'h1, 2'b00);
        rdf(OPC_LOCK_READ, 24'h01abcd, 1, 24'h030000);
        bp <= 3'h1;
        prog(1'b1, 24'h0f0010, 16'h0000, 1);
        chk("wip_prot", 32'(write_in_progress), 32'h0);
        close_out();
    end
endmodule
